// ---- rtl/emac_fc_pkg.sv ----
package emac_fc_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_RX_PAUSE_OPERAND   = 32'hb000_30bc;
	localparam logic [31:0] ADDR_RX_PAUSE_REMAINING = 32'hb000_30c0;
	localparam logic [31:0] ADDR_TX_PAUSE_REMAINING = 32'hb000_30c4;
	localparam logic [31:0] ADDR_RX_LENGTH_TYPE     = 32'hb000_30c8;
	localparam logic [31:0] ADDR_TX_DESC_CUR        = 32'hb000_30cc;
	localparam logic [31:0] ADDR_TX_BUF_CUR         = 32'hb000_30d0;
	localparam logic [31:0] ADDR_RX_DESC_CUR        = 32'hb000_30d4;
	localparam logic [31:0] ADDR_RX_BUF_CUR         = 32'hb000_30d8;
	localparam logic [31:0] ADDR_MAC_COMMAND        = 32'hb000_30e0;
	localparam logic [31:0] ADDR_IRQ_STATUS         = 32'hb000_30e4;
	localparam logic [31:0] ADDR_IRQ_ENABLE         = 32'hb000_30e8;
	localparam logic [31:0] ADDR_GEN_STATUS         = 32'hb000_30ec;
	localparam logic [31:0] ADDR_TX_START_DEMAND    = 32'hb000_30f0;
	localparam logic [31:0] ADDR_RX_START_DEMAND    = 32'hb000_30f4;

	// widths and reset values
	localparam int          DATA_W  = 32;
	localparam int          FIELD_W = 16;
	localparam logic [31:0] ZERO32  = 32'h0000_0000;
	localparam logic [15:0] ZERO16  = 16'h0000;

	// mac_command_reg fields
	localparam int          CMD_W          = 7;
	localparam int          CMD_TX_ON      = 0;
	localparam int          CMD_RX_ON      = 1;
	localparam int          CMD_FULL_DUPLEX_SELECT       = 2;
	localparam int          CMD_LOOPBACK   = 3;
	localparam int          CMD_SEND_PAUSE = 4;
	localparam int          CMD_MDC_EN     = 5;
	localparam int          CMD_SPEED_100  = 6;
	localparam logic [6:0]  CMD_RESET      = 7'h00;

	// irq status / enable fields
	localparam int          IRQ_W       = 5;
	localparam int          IRQ_LEN     = 0;
	localparam int          IRQ_TDU     = 1;
	localparam int          IRQ_RDU     = 2;
	localparam int          IRQ_TX_BUS_ERROR  = 3;
	localparam int          IRQ_RX_BUS_ERROR  = 4;
	localparam logic [4:0]  IRQ_RESET   = 5'h00;

	// general status field
	localparam int          GSTA_PAUSED = 9;

	// slot time of 512 bit times, rounded up to whole clocks
	localparam int          CLK_PERIOD_NS = 25;
	localparam int          SLOT_NS_100   = 5120;
	localparam int          SLOT_NS_10    = 51200;
	localparam int          SLOT_W        = 12;
	localparam logic [11:0] SLOT_CYC_100  = 12'((SLOT_NS_100 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] SLOT_CYC_10   = 12'((SLOT_NS_10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] SLOT_ONE      = 12'h001;

endpackage

// ---- rtl/pause_timer_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface pause_timer_if;
	import emac_fc_pkg::*;
	logic               tick;  // one slot time elapsed
	logic               load;  // load a new operand
	logic [FIELD_W-1:0] value; // operand to load
	logic [FIELD_W-1:0] count; // live timer value

	modport ctl (output tick, output load, output value, input count);
	modport tmr (input tick, input load, input value, output count);
endinterface
`default_nettype wire

// ---- rtl/slot_tick_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module slot_tick_gen
	import emac_fc_pkg::*;
(
	input  wire logic pclk,      // system clock
	input  wire logic presetn,   // async reset, low
	input  wire logic speed_100, // 1: 100 Mb/s slot
	output var  logic tick       // one-cycle slot pulse
);
	logic [SLOT_W-1:0] cnt_r;
	logic [SLOT_W-1:0] cnt_nxt;
	logic              tick_nxt;

	// count down one slot, pulse at the end
	always_comb begin
		tick_nxt = 1'b0;
		cnt_nxt  = cnt_r - SLOT_ONE;
		if (cnt_r <= SLOT_ONE) begin
			tick_nxt = 1'b1;
			cnt_nxt  = speed_100 ? SLOT_CYC_100 : SLOT_CYC_10;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= SLOT_CYC_10;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/pause_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module pause_timer
	import emac_fc_pkg::*;
(
	input  wire logic   pclk,    // system clock
	input  wire logic   presetn, // async reset, low
	pause_timer_if.tmr  t        // load / tick / count
);
	logic [FIELD_W-1:0] cnt_r;
	logic [FIELD_W-1:0] cnt_nxt;

	// reload beats decrement; stop at zero
	always_comb begin
		cnt_nxt = cnt_r;
		if (t.load) begin
			cnt_nxt = t.value;
		end else if (t.tick && cnt_r != ZERO16) begin
			cnt_nxt = cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= ZERO16;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign t.count = cnt_r;
endmodule
`default_nettype wire

// ---- rtl/emac_flow_status.sv ----
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module emac_flow_status
	import emac_fc_pkg::*;
(
	input  wire logic               pclk,             // system clock, 40 MHz
	input  wire logic               presetn,          // async reset, low
	input  wire logic               psel,             // apb select
	input  wire logic               penable,          // apb access phase
	input  wire logic               pwrite,           // apb write
	input  wire logic [31:0]        paddr,            // apb byte address
	input  wire logic [31:0]        pwdata,           // apb write data
	output var  logic [31:0]        prdata,           // apb read data
	output var  logic               pready,           // apb ready
	output var  logic               pslverr,          // apb error, unmapped
	input  wire logic               rx_pause_rcvd,    // pulse: pause frame received
	input  wire logic [FIELD_W-1:0] rx_pause_value,   // its operand
	input  wire logic               tx_pause_sent,    // pulse: pause frame sent
	input  wire logic [FIELD_W-1:0] tx_pause_value,   // its operand
	input  wire logic               rx_len_valid,     // pulse: length/type seen
	input  wire logic [FIELD_W-1:0] rx_len_value,     // length/type field
	input  wire logic [31:0]        tx_desc_addr_in,  // tx dma descriptor
	input  wire logic [31:0]        tx_buf_addr_in,   // tx dma buffer
	input  wire logic [31:0]        rx_desc_addr_in,  // rx dma descriptor
	input  wire logic [31:0]        rx_buf_addr_in,   // rx dma buffer
	input  wire logic               tx_desc_miss,     // pulse: no tx descriptor
	input  wire logic               rx_desc_miss,     // pulse: no rx descriptor
	input  wire logic               tx_bus_err,       // pulse: tx dma bus error
	input  wire logic               rx_bus_err,       // pulse: rx dma bus error
	output var  logic               tx_enable,        // tx may start frames
	output var  logic               rx_enable,        // rx may take frames
	output var  logic               send_pause_req,   // send a pause frame
	output var  logic               loopback_en,      // internal loop-back
	output var  logic               full_duplex,      // effective duplex
	output var  logic               mgmt_clk_en,      // management clock on
	output var  logic               mac_irq           // interrupt, high
);
	pause_timer_if rx_t ();
	pause_timer_if tx_t ();

	logic slot_tick;

	// register state
	logic [CMD_W-1:0]   cmd_r,     cmd_nxt;
	logic [IRQ_W-1:0]   ista_r,    ista_nxt;
	logic [IRQ_W-1:0]   ien_r,     ien_nxt;
	logic [FIELD_W-1:0] rx_op_r,   rx_op_nxt;
	logic [FIELD_W-1:0] lt_r,      lt_nxt;
	logic [31:0]        txd_r,     txb_r;
	logic [31:0]        rxd_r,     rxb_r;
	logic               tx_halt_r, tx_halt_nxt;
	logic               rx_halt_r, rx_halt_nxt;

	// bus side
	logic [31:0]        rd_data;
	logic               rd_hit;
	logic               wr_en;
	logic [31:0]        prdata_nxt;
	logic               pready_nxt;
	logic               pslverr_nxt;

	// derived control
	logic               fdx_eff;
	logic               rx_paused;
	logic               paused;
	logic               tx_enable_nxt;
	logic               rx_enable_nxt;
	logic               send_pause_nxt;
	logic               irq_nxt;

	// slot time base at the selected line speed
	slot_tick_gen u_tick (
		.pclk      (pclk),
		.presetn   (presetn),
		.speed_100 (cmd_r[CMD_SPEED_100]),
		.tick      (slot_tick)
	);

	// receive pause timer
	pause_timer u_rx_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (rx_t.tmr)
	);

	// transmit (remote) pause timer
	pause_timer u_tx_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (tx_t.tmr)
	);

	// loop-back implies full duplex whatever the duplex bit
	assign fdx_eff   = cmd_r[CMD_LOOPBACK] | cmd_r[CMD_FULL_DUPLEX_SELECT];
	assign rx_paused = rx_t.count != ZERO16;
	assign paused    = rx_paused | cmd_r[CMD_SEND_PAUSE];

	// timer feeds; received pause frames only count in full duplex
	assign rx_t.tick  = slot_tick;
	assign rx_t.load  = rx_pause_rcvd & fdx_eff;
	assign rx_t.value = rx_pause_value;
	assign tx_t.tick  = slot_tick;
	assign tx_t.load  = tx_pause_sent;
	assign tx_t.value = tx_pause_value;

	// write strobe at the completing access edge
	assign wr_en = psel & penable & pready & pwrite;

	// read decode
	always_comb begin
		rd_data = ZERO32;
		rd_hit  = 1'b1;
		case (paddr)
			ADDR_RX_PAUSE_OPERAND: begin
				rd_data[FIELD_W-1:0] = rx_op_r;
			end
			ADDR_RX_PAUSE_REMAINING: begin
				rd_data[FIELD_W-1:0] = rx_t.count;
			end
			ADDR_TX_PAUSE_REMAINING: begin
				rd_data[FIELD_W-1:0] = tx_t.count;
			end
			ADDR_RX_LENGTH_TYPE: begin
				rd_data[FIELD_W-1:0] = lt_r;
			end
			ADDR_TX_DESC_CUR: begin
				rd_data = txd_r;
			end
			ADDR_TX_BUF_CUR: begin
				rd_data = txb_r;
			end
			ADDR_RX_DESC_CUR: begin
				rd_data = rxd_r;
			end
			ADDR_RX_BUF_CUR: begin
				rd_data = rxb_r;
			end
			ADDR_MAC_COMMAND: begin
				rd_data[CMD_W-1:0] = cmd_r;
			end
			ADDR_IRQ_STATUS: begin
				rd_data[IRQ_W-1:0] = ista_r;
			end
			ADDR_IRQ_ENABLE: begin
				rd_data[IRQ_W-1:0] = ien_r;
			end
			ADDR_GEN_STATUS: begin
				rd_data[GSTA_PAUSED] = paused;
			end
			ADDR_TX_START_DEMAND: begin
				rd_data = ZERO32;
			end
			ADDR_RX_START_DEMAND: begin
				rd_data = ZERO32;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// apb answer: ready in the first access cycle, no waits
	always_comb begin
		prdata_nxt  = prdata;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		if (psel && !penable) begin
			pready_nxt  = 1'b1;
			prdata_nxt  = rd_data;
			pslverr_nxt = !rd_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= ZERO32;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= prdata_nxt;
			pready  <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end

	// command register; send-pause drops once the frame is out
	always_comb begin
		cmd_nxt = cmd_r;
		if (wr_en && paddr == ADDR_MAC_COMMAND) begin
			cmd_nxt = pwdata[CMD_W-1:0];
		end
		if (tx_pause_sent) begin
			cmd_nxt[CMD_SEND_PAUSE] = 1'b0;
		end
	end

	// interrupt enables
	always_comb begin
		ien_nxt = ien_r;
		if (wr_en && paddr == ADDR_IRQ_ENABLE) begin
			ien_nxt = pwdata[IRQ_W-1:0];
		end
	end

	// sticky status, write one clears, new event wins
	always_comb begin
		ista_nxt = ista_r;
		if (wr_en && paddr == ADDR_IRQ_STATUS) begin
			ista_nxt = ista_r & ~pwdata[IRQ_W-1:0];
		end
		if (rx_len_valid && ien_r[IRQ_LEN]) begin
			ista_nxt[IRQ_LEN] = 1'b1;
		end
		if (tx_desc_miss) begin
			ista_nxt[IRQ_TDU] = 1'b1;
		end
		if (rx_desc_miss) begin
			ista_nxt[IRQ_RDU] = 1'b1;
		end
		if (tx_bus_err) begin
			ista_nxt[IRQ_TX_BUS_ERROR] = 1'b1;
		end
		if (rx_bus_err) begin
			ista_nxt[IRQ_RX_BUS_ERROR] = 1'b1;
		end
	end

	// length/type capture with bitwise write-one-clear
	always_comb begin
		lt_nxt = lt_r;
		if (wr_en && paddr == ADDR_RX_LENGTH_TYPE) begin
			lt_nxt = lt_r & ~pwdata[FIELD_W-1:0];
		end
		if (rx_len_valid) begin
			lt_nxt = rx_len_value;
		end
	end

	// operand kept while a receive pause is running
	always_comb begin
		rx_op_nxt = rx_op_r;
		if (rx_t.load && !rx_paused) begin
			rx_op_nxt = rx_pause_value;
		end
	end

	// direction stop on missing descriptor, resume on demand
	always_comb begin
		tx_halt_nxt = tx_halt_r;
		rx_halt_nxt = rx_halt_r;
		if (wr_en && paddr == ADDR_TX_START_DEMAND) begin
			tx_halt_nxt = 1'b0;
		end
		if (wr_en && paddr == ADDR_RX_START_DEMAND) begin
			rx_halt_nxt = 1'b0;
		end
		if (tx_desc_miss) begin
			tx_halt_nxt = 1'b1;
		end
		if (rx_desc_miss) begin
			rx_halt_nxt = 1'b1;
		end
	end

	// pin-side controls
	always_comb begin
		tx_enable_nxt  = cmd_r[CMD_TX_ON] & ~tx_halt_r & ~rx_paused;
		rx_enable_nxt  = cmd_r[CMD_RX_ON] & ~rx_halt_r;
		send_pause_nxt = cmd_r[CMD_SEND_PAUSE] & fdx_eff;
		irq_nxt        = |(ista_r & ien_r);
	end

	// register bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_r     <= CMD_RESET;
			ien_r     <= IRQ_RESET;
			ista_r    <= IRQ_RESET;
			lt_r      <= ZERO16;
			rx_op_r   <= ZERO16;
			tx_halt_r <= 1'b0;
			rx_halt_r <= 1'b0;
		end else begin
			cmd_r     <= cmd_nxt;
			ien_r     <= ien_nxt;
			ista_r    <= ista_nxt;
			lt_r      <= lt_nxt;
			rx_op_r   <= rx_op_nxt;
			tx_halt_r <= tx_halt_nxt;
			rx_halt_r <= rx_halt_nxt;
		end
	end

	// current dma addresses follow the engines; bus writes ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_r <= ZERO32;
			txb_r <= ZERO32;
			rxd_r <= ZERO32;
			rxb_r <= ZERO32;
		end else begin
			txd_r <= tx_desc_addr_in;
			txb_r <= tx_buf_addr_in;
			rxd_r <= rx_desc_addr_in;
			rxb_r <= rx_buf_addr_in;
		end
	end

	// registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_enable      <= 1'b0;
			rx_enable      <= 1'b0;
			send_pause_req <= 1'b0;
			loopback_en    <= 1'b0;
			full_duplex    <= 1'b0;
			mgmt_clk_en    <= 1'b0;
			mac_irq        <= 1'b0;
		end else begin
			tx_enable      <= tx_enable_nxt;
			rx_enable      <= rx_enable_nxt;
			send_pause_req <= send_pause_nxt;
			loopback_en    <= cmd_r[CMD_LOOPBACK];
			full_duplex    <= fdx_eff;
			mgmt_clk_en    <= cmd_r[CMD_MDC_EN];
			mac_irq        <= irq_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- verif/far_side_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module far_side_model
	import emac_fc_pkg::*;
(
	input  wire logic        pclk,    // clock
	input  wire logic        presetn, // reset, low
	input  wire logic        go,      // event request
	input  wire logic [3:0]  kind,    // event kind
	input  wire logic [31:0] val,     // event value
	output var  logic [6:0]  pulse,   // event pulses
	output var  logic [15:0] fld,     // operand or length
	output var  logic [31:0] adr [4]  // live dma addresses
);
	int seed = 7;

	// one-cycle pulse; value line is noise outside it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse <= '0;
			fld <= ZERO16;
			foreach (adr[i]) adr[i] <= ZERO32;
		end else begin
			pulse <= '0;
			fld <= 16'($random(seed));
			if (go && kind < 4'h7) begin
				pulse[kind] <= 1'b1;
				fld <= val[15:0];
			end
			if (go && kind >= 4'h7) begin
				adr[kind - 4'h7] <= val;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/emac_flow_status_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module emac_flow_status_properties
	import emac_fc_pkg::*;
(
	input wire logic               pclk,           // clock
	input wire logic               presetn,        // reset
	input wire logic               psel,           // select
	input wire logic               penable,        // access
	input wire logic [31:0]        prdata,         // read data
	input wire logic               pready,         // ready
	input wire logic               pslverr,        // error
	input wire logic               rx_pause_rcvd,  // pause in
	input wire logic [FIELD_W-1:0] rx_pause_value, // operand
	input wire logic               tx_pause_sent,  // pause out
	input wire logic               tx_desc_miss,   // tx miss
	input wire logic               rx_desc_miss,   // rx miss
	input wire logic               tx_enable,      // tx go
	input wire logic               rx_enable,      // rx go
	input wire logic               send_pause_req, // send
	input wire logic               loopback_en,    // loop
	input wire logic               full_duplex     // duplex
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// bus answer timing
	ready_in_time_a: assert property (psel && !penable |=> pready)
		else $error("pready late");
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	ready_single_a: assert property (pready |=> !pready)
		else $error("pready held");
	slverr_data_a: assert property (pslverr |-> pready && prdata == ZERO32)
		else $error("error read not zero");
	// flow control and descriptor effects
	pause_holdoff_a: assert property (rx_pause_rcvd && rx_pause_value != ZERO16 ##1 full_duplex |-> ##1 !tx_enable)
		else $error("tx not held off");
	tx_miss_stop_a: assert property (tx_desc_miss |-> ##2 !tx_enable)
		else $error("tx not stopped");
	rx_miss_stop_a: assert property (rx_desc_miss |-> ##2 !rx_enable)
		else $error("rx not stopped");
	loop_duplex_a: assert property (loopback_en && $past(loopback_en) |-> full_duplex)
		else $error("loopback not duplex");
	pause_duplex_a: assert property (send_pause_req |-> full_duplex)
		else $error("pause send in half duplex");
	send_clear_a: assert property (tx_pause_sent |-> ##2 !send_pause_req)
		else $error("send pause not cleared");
endmodule

bind emac_flow_status emac_flow_status_properties u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rx_pause_rcvd(rx_pause_rcvd),
	.rx_pause_value(rx_pause_value), .tx_pause_sent(tx_pause_sent),
	.tx_desc_miss(tx_desc_miss), .rx_desc_miss(rx_desc_miss), .tx_enable(tx_enable),
	.rx_enable(rx_enable), .send_pause_req(send_pause_req), .loopback_en(loopback_en),
	.full_duplex(full_duplex)
);
`default_nettype wire

// ---- verif/tb_emac_flow_status.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_emac_flow_status
	import emac_fc_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = ZERO32;
	logic [31:0] pwdata = ZERO32;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic        go = 1'b0;
	logic [3:0]  kind = 4'h0;
	logic [31:0] val = ZERO32;
	logic [6:0]  pulse;
	logic [15:0] fld;
	logic [31:0] adr [4];
	logic        tx_enable, rx_enable, send_pause_req, loopback_en, full_duplex, mgmt_clk_en, mac_irq;
	int          error_cnt = 0, check_count = 0, seed = 49612, cnt = 0, n;
	logic [33:0] q [$];
	logic [31:0] r;
	logic [31:0] a [8];

	always #12.5 pclk = ~pclk;
	always @(posedge pclk) cnt <= cnt + 1;

	emac_flow_status DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_pause_rcvd(pulse[0]), .rx_pause_value(fld), .tx_pause_sent(pulse[1]),
		.tx_pause_value(fld), .rx_len_valid(pulse[2]), .rx_len_value(fld),
		.tx_desc_addr_in(adr[0]), .tx_buf_addr_in(adr[1]), .rx_desc_addr_in(adr[2]),
		.rx_buf_addr_in(adr[3]), .tx_desc_miss(pulse[3]), .rx_desc_miss(pulse[4]),
		.tx_bus_err(pulse[5]), .rx_bus_err(pulse[6]), .tx_enable(tx_enable),
		.rx_enable(rx_enable), .send_pause_req(send_pause_req), .loopback_en(loopback_en),
		.full_duplex(full_duplex), .mgmt_clk_en(mgmt_clk_en), .mac_irq(mac_irq)
	);
	far_side_model u_far (
		.pclk(pclk), .presetn(presetn), .go(go), .kind(kind), .val(val),
		.pulse(pulse), .fld(fld), .adr(adr)
	);

	task automatic report_and_stop();
		$display("counts: %0d checks, %0d mismatches", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// compare one pin state
	task automatic chk_pin(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t pin %b want %b", $time, got, exp);
		end
	endtask
	// compare one read answer against its note {tolerance, slverr, data}
	task automatic chk_rd(input logic [33:0] note);
		check_count++;
		if (!({pslverr, prdata} === note[32:0] || (note[33] && {pslverr, prdata} === note[32:0] - 33'd1))) begin
			error_cnt++;
			$display("BAD %0t read %h want %h", $time, {pslverr, prdata}, note[32:0]);
		end
	endtask
	// one transfer, held until pready; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read with note {tolerance, slverr, data}
	task automatic rd(input logic [31:0] ad, input logic [31:0] e, input logic tol = 1'b0,
			input logic err = 1'b0);
		q.push_back({tol, err, e});
		apb(1'b0, ad, ZERO32);
	endtask
	// far side event, then let it land
	task automatic ev(input logic [3:0] k, input logic [31:0] v);
		@(posedge pclk);
		go <= 1'b1;
		kind <= k;
		val <= v;
		@(posedge pclk);
		go <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask

	// read answers against oldest note; a timer may have ticked once
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk_rd(q.pop_front());
		end
	end

	// watchdog well beyond the expected few thousand cycles
	initial begin
		#2_000_000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		a = '{ADDR_RX_PAUSE_OPERAND, ADDR_RX_PAUSE_REMAINING, ADDR_TX_PAUSE_REMAINING, ADDR_RX_LENGTH_TYPE,
			ADDR_TX_DESC_CUR, ADDR_TX_BUF_CUR, ADDR_RX_DESC_CUR, ADDR_RX_BUF_CUR};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (a[i]) rd(a[i], ZERO32);
		foreach (a[i]) apb(1'b1, a[i], $random(seed));
		foreach (a[i]) rd(a[i], ZERO32);
		rd(32'hb000_3100, ZERO32, 1'b0, 1'b1);
		$display("test registers done");
		apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_001f);
		apb(1'b1, ADDR_MAC_COMMAND, 32'h0000_0067);
		// let the long first slot after reset run out, so ticks follow 100 Mb/s
		cyc(int'(SLOT_CYC_10));
		chk_pin(mgmt_clk_en, 1'b1);
		chk_pin(tx_enable & rx_enable & full_duplex, 1'b1);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			ev(4'(7 + i), r);
			rd(a[4 + i], r);
		end
		r = {ZERO16, 16'($random(seed))};
		ev(4'h2, r);
		rd(ADDR_RX_LENGTH_TYPE, r);
		rd(ADDR_IRQ_STATUS, 32'h0000_0001);
		chk_pin(mac_irq, 1'b1);
		apb(1'b1, ADDR_RX_LENGTH_TYPE, 32'h0000_00ff);
		rd(ADDR_RX_LENGTH_TYPE, r & 32'h0000_ff00);
		apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
		cyc(2);
		chk_pin(mac_irq, 1'b0);
		$display("test addresses and length done");
		ev(4'h0, 32'h0000_0003);
		rd(ADDR_RX_PAUSE_OPERAND, 32'h0000_0003);
		rd(ADDR_RX_PAUSE_REMAINING, 32'h0000_0003, 1'b1);
		rd(ADDR_GEN_STATUS, 32'h0000_0200);
		chk_pin(tx_enable, 1'b0);
		n = cnt;
		ev(4'h0, 32'h0000_0005);
		rd(ADDR_RX_PAUSE_REMAINING, 32'h0000_0005, 1'b1);
		rd(ADDR_RX_PAUSE_OPERAND, 32'h0000_0003);
		while (tx_enable !== 1'b1 && cnt - n < 4000) @(posedge pclk);
		chk_pin(cnt - n >= 4 * SLOT_CYC_100 && cnt - n <= 6 * SLOT_CYC_100, 1'b1);
		rd(ADDR_RX_PAUSE_REMAINING, ZERO32);
		rd(ADDR_GEN_STATUS, ZERO32);
		ev(4'h1, 32'h0000_0004);
		rd(ADDR_TX_PAUSE_REMAINING, 32'h0000_0004, 1'b1);
		$display("test pause timers done");
		ev(4'h3, ZERO32);
		cyc(1);
		chk_pin(tx_enable, 1'b0);
		apb(1'b1, ADDR_TX_START_DEMAND, ZERO32);
		ev(4'h4, ZERO32);
		cyc(1);
		chk_pin(rx_enable | !tx_enable, 1'b0);
		apb(1'b1, ADDR_RX_START_DEMAND, ZERO32);
		ev(4'h5, ZERO32);
		ev(4'h6, ZERO32);
		rd(ADDR_IRQ_STATUS, 32'h0000_001e);
		chk_pin(mac_irq & rx_enable, 1'b1);
		apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_001f);
		rd(ADDR_IRQ_STATUS, ZERO32);
		$display("test descriptors done");
		apb(1'b1, ADDR_MAC_COMMAND, 32'h0000_005b);
		cyc(2);
		chk_pin(loopback_en & full_duplex, 1'b1);
		chk_pin(send_pause_req, 1'b1);
		rd(ADDR_GEN_STATUS, 32'h0000_0200);
		ev(4'h1, 32'h0000_0002);
		cyc(1);
		chk_pin(send_pause_req, 1'b0);
		apb(1'b1, ADDR_MAC_COMMAND, 32'h0000_0053);
		cyc(2);
		chk_pin(send_pause_req | full_duplex, 1'b0);
		ev(4'h0, 32'h0000_0007);
		rd(ADDR_RX_PAUSE_REMAINING, ZERO32);
		chk_pin(tx_enable, 1'b1);
		apb(1'b1, ADDR_IRQ_ENABLE, ZERO32);
		r = {ZERO16, 16'($random(seed))};
		ev(4'h2, r);
		rd(ADDR_RX_LENGTH_TYPE, r);
		rd(ADDR_IRQ_STATUS, ZERO32);
		$display("test duplex done");
		report_and_stop();
	end
endmodule
`default_nettype wire
